//--- shared/dsd_params.svh
// Constants for the data space decoder and access timing logic
`ifndef DSD_PARAMS_SVH
`define DSD_PARAMS_SVH

// ----------------------------------------------------------------
// Region bounds (first address past each region)
// ----------------------------------------------------------------
`define REGF_END        16'h0020
`define STDIO_END       16'h0060
`define XIO_END         16'h0100
`define SRAM_END_NORM   16'h1100
`define SRAM_END_COMP   16'h1000
`define IO_BASE         16'h0020

// ----------------------------------------------------------------
// Own register data addresses inside standard I/O
// ----------------------------------------------------------------
`define ADDR_MCU_CTRL   16'h0055
`define ADDR_EE_CTRL    16'h003C
`define ADDR_EE_DATA    16'h003D
`define ADDR_EE_ADDR_LO 16'h003E
`define ADDR_EE_ADDR_HI 16'h003F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MCU_SRE_BIT     7
`define MCU_WAIT_LSB    2
`define EEC_RDY_IE_BIT  3
`define EEC_ARM_BIT     2
`define EEC_WR_BIT      1
`define EEC_RD_BIT      0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MCU_CTRL_RST    8'h00
`define EEPROM_ADDR_REG_RST        12'h000
`define EEPROM_DATA_REG_RST        8'h00

// ----------------------------------------------------------------
// Timing counts in core clock cycles
// ----------------------------------------------------------------
`define EE_RD_HOLD      3'h4
`define EE_WR_HOLD      3'h2
`define ARM_WINDOW      3'h4
`define EXT_BYTE_BASE   4'h1
`define EXT_PAIR_BASE   4'h3

`endif

//--- shared/dsd_pkg.sv
// Types shared by the data space decoder modules
package dsd_pkg;

	// Access sequencer states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_ACCESS = 3'b010,
		ST_EXT    = 3'b100
	} state_t;

	// Decoded target region
	typedef enum logic [2:0] {
		RG_REGF  = 3'h0,
		RG_STDIO = 3'h1,
		RG_XIO   = 3'h2,
		RG_SRAM  = 3'h3,
		RG_EXT   = 3'h4
	} region_t;

	// Data addressing modes
	typedef enum logic [2:0] {
		AM_DIRECT  = 3'h0,
		AM_DISP    = 3'h1,
		AM_IND     = 3'h2,
		AM_PREDEC  = 3'h3,
		AM_POSTINC = 3'h4
	} addr_mode_t;

	// Complete state of the top module
	typedef struct packed {
		state_t      state;
		logic [3:0]  cnt;
		logic [2:0]  hold;
		logic [2:0]  arm_cnt;
		logic        arm;
		logic        rdy_ie;
		logic        ext_mem_enable;
		logic [1:0]  wait_st;
		logic [11:0] eeprom_addr_reg;
		logic [7:0]  eeprom_data_reg;
		logic        comp_meta;
		logic        comp_sync;
		logic        own_hit;
		logic        ext_null;
		logic        is_rd;
		logic [15:0] laddr;
		logic        sel_regf;
		logic        sel_stdio;
		logic        sel_xio;
		logic        sel_sram;
		logic        mem_we;
		logic [7:0]  mem_wdata;
		logic        done;
		logic        stall;
		logic [7:0]  rdata;
		logic        ptr_wb;
		logic [15:0] ptr_new;
		logic        ext_rd;
		logic        ext_wr;
		logic [15:0] ext_addr;
		logic [7:0]  ext_wdata;
		logic        eep_rd;
		logic        eep_wr;
	} core_state_t;

endpackage : dsd_pkg

//--- design/ds_addr_decode.sv
// Effective address generation and data space region decode
`timescale 1ns/1ps
`include "dsd_params.svh"

module ds_addr_decode (
	input  wire dsd_pkg::addr_mode_t addr_mode_i,
	input  wire logic [1:0]          ptr_sel_i,
	input  wire logic [15:0]         ptr_base_i,
	input  wire logic [5:0]          disp_i,
	input  wire logic [15:0]         direct_addr_i,
	input  wire logic                io_insn_i,
	input  wire logic                compat_i,
	output logic [15:0]              eff_addr_o,
	output logic                     ptr_wb_o,
	output logic [15:0]              ptr_new_o,
	output dsd_pkg::region_t         region_o
);

	// ----------------------------------------------------------------
	// Address generation
	// ----------------------------------------------------------------
	always_comb begin
		eff_addr_o = direct_addr_i;
		ptr_wb_o   = 1'b0;
		ptr_new_o  = ptr_base_i;
		if (io_insn_i) begin
			// Short port index only reaches standard I/O
			eff_addr_o = `IO_BASE + {10'h000, direct_addr_i[5:0]};
		end else begin
			case (addr_mode_i)
				dsd_pkg::AM_DISP: begin
					// Displacement only with the three upper pointers
					eff_addr_o = (ptr_sel_i != 2'h0) ?
						ptr_base_i + {10'h000, disp_i} : ptr_base_i;
				end
				dsd_pkg::AM_IND: begin
					eff_addr_o = ptr_base_i;
				end
				dsd_pkg::AM_PREDEC: begin
					ptr_new_o  = ptr_base_i - 16'h0001;
					eff_addr_o = ptr_new_o;
					ptr_wb_o   = 1'b1;
				end
				dsd_pkg::AM_POSTINC: begin
					eff_addr_o = ptr_base_i;
					ptr_new_o  = ptr_base_i + 16'h0001;
					ptr_wb_o   = 1'b1;
				end
				default: begin
					eff_addr_o = direct_addr_i;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Region decode; legacy map has no extended I/O
	// ----------------------------------------------------------------
	always_comb begin
		if (eff_addr_o < `REGF_END) begin
			region_o = dsd_pkg::RG_REGF;
		end else if (eff_addr_o < `STDIO_END) begin
			region_o = dsd_pkg::RG_STDIO;
		end else if (compat_i) begin
			region_o = (eff_addr_o < `SRAM_END_COMP) ?
				dsd_pkg::RG_SRAM : dsd_pkg::RG_EXT;
		end else if (eff_addr_o < `XIO_END) begin
			region_o = dsd_pkg::RG_XIO;
		end else if (eff_addr_o < `SRAM_END_NORM) begin
			region_o = dsd_pkg::RG_SRAM;
		end else begin
			region_o = dsd_pkg::RG_EXT;
		end
	end

endmodule : ds_addr_decode

//--- design/data_space_decoder_timing.sv
// Data space decoder, access sequencer and EEPROM access registers
`timescale 1ns/1ps
`include "dsd_params.svh"

// Operation
// - Normal map: regs, I/O, extended I/O, SRAM
// - Legacy map drops extended I/O, 4000 SRAM
// - Short I/O instructions never reach extended I/O
// - Addresses past internal region go external
// - External access only with enable bit set
// - Internal accesses keep external strobes inactive
// - External byte takes one extra cycle
// - External stack pair costs three extra cycles
// - Wait states add two, three, four cycles
// - Stack pair with waits adds five, seven, nine
// - Internal access completes within two cycles
// - Displacement up to 63 on upper pointers
// - Pre-decrement, post-increment pointer written back
// - EEPROM read stalls four, write two cycles
// - EEPROM reached indirectly, 4K single bytes
// - EEPROM registers decoded in standard I/O
// - Address register 12 bits, top four zero
// - Address zero at reset, software loads it
// - Write needs arm bit, arm expires after four
module data_space_decoder_timing (
	input  wire logic                core_clk_i,
	input  wire logic                reset_i,
	input  wire logic                compat_mode_i,
	input  wire logic                req_i,
	input  wire logic                we_i,
	input  wire logic                io_insn_i,
	input  wire logic                pair_i,
	input  wire dsd_pkg::addr_mode_t addr_mode_i,
	input  wire logic [1:0]          ptr_sel_i,
	input  wire logic [15:0]         ptr_base_i,
	input  wire logic [5:0]          disp_i,
	input  wire logic [15:0]         direct_addr_i,
	input  wire logic [7:0]          wdata_i,
	input  wire logic [7:0]          int_rdata_i,
	input  wire logic [7:0]          ext_rdata_i,
	input  wire logic [7:0]          eep_rdata_i,
	input  wire logic                eep_busy_i,
	output logic                     done_o,
	output logic                     stall_o,
	output logic [7:0]               rdata_o,
	output logic                     ptr_wb_o,
	output logic [15:0]              ptr_new_o,
	output logic                     sel_regfile_o,
	output logic                     sel_std_io_o,
	output logic                     sel_ext_io_o,
	output logic                     sel_sram_o,
	output logic [15:0]              local_addr_o,
	output logic                     mem_we_o,
	output logic [7:0]               mem_wdata_o,
	output logic                     ext_rd_o,
	output logic                     ext_wr_o,
	output logic [15:0]              ext_addr_o,
	output logic [7:0]               ext_wdata_o,
	output logic [11:0]              eep_addr_o,
	output logic [7:0]               eep_wdata_o,
	output logic                     eep_rd_o,
	output logic                     eep_wr_o
);

	dsd_pkg::core_state_t s;
	dsd_pkg::core_state_t next_s;
	logic [15:0]          eff_addr;
	logic                 dec_wb;
	logic [15:0]          dec_new;
	dsd_pkg::region_t     region;
	logic                 take;
	logic                 own;
	logic                 go_ext;
	logic [7:0]           own_rd;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	ds_addr_decode u_decode (
		.addr_mode_i   (addr_mode_i),
		.ptr_sel_i     (ptr_sel_i),
		.ptr_base_i    (ptr_base_i),
		.disp_i        (disp_i),
		.direct_addr_i (direct_addr_i),
		.io_insn_i     (io_insn_i),
		.compat_i      (s.comp_sync),
		.eff_addr_o    (eff_addr),
		.ptr_wb_o      (dec_wb),
		.ptr_new_o     (dec_new),
		.region_o      (region)
	);

	// Request qualification and own register hit
	assign take   = (s.state == dsd_pkg::ST_IDLE) && req_i;
	assign go_ext = (region == dsd_pkg::RG_EXT) && s.ext_mem_enable;
	assign own    = (region == dsd_pkg::RG_STDIO) &&
		((eff_addr == `ADDR_MCU_CTRL) || (eff_addr == `ADDR_EE_CTRL) ||
		(eff_addr == `ADDR_EE_DATA) || (eff_addr == `ADDR_EE_ADDR_LO) ||
		(eff_addr == `ADDR_EE_ADDR_HI));

	// ----------------------------------------------------------------
	// Own register read mux
	// ----------------------------------------------------------------
	always_comb begin
		case (s.laddr)
			`ADDR_MCU_CTRL:   own_rd = {s.ext_mem_enable, 3'h0, s.wait_st, 2'h0};
			`ADDR_EE_CTRL:    own_rd = {4'h0, s.rdy_ie, s.arm,
				eep_busy_i | s.eep_wr, 1'b0};
			`ADDR_EE_DATA:    own_rd = s.eeprom_data_reg;
			`ADDR_EE_ADDR_LO: own_rd = s.eeprom_addr_reg[7:0];
			`ADDR_EE_ADDR_HI: own_rd = {4'h0, s.eeprom_addr_reg[11:8]};
			default:          own_rd = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s           = s;
		next_s.comp_meta = compat_mode_i;
		next_s.comp_sync = s.comp_meta;
		next_s.done      = 1'b0;
		next_s.ptr_wb    = 1'b0;
		next_s.eep_rd    = 1'b0;
		next_s.eep_wr    = 1'b0;
		// Arm window timer; a new arm write restarts it
		if (s.arm_cnt != 3'h0) begin
			next_s.arm_cnt = s.arm_cnt - 3'h1;
			if (s.arm_cnt == 3'h1) begin
				next_s.arm = 1'b0;
			end
		end
		// EEPROM stall count
		if (s.hold != 3'h0) begin
			next_s.hold = s.hold - 3'h1;
		end
		// Read data lands in the data register one cycle on
		if (s.eep_rd) begin
			next_s.eeprom_data_reg = eep_rdata_i;
		end
		case (s.state)
			dsd_pkg::ST_IDLE: begin
				if (take) begin
					next_s.laddr     = eff_addr;
					next_s.is_rd     = !we_i;
					next_s.own_hit   = own;
					next_s.ptr_wb    = dec_wb;
					next_s.ptr_new   = dec_new;
					next_s.sel_regf  = region == dsd_pkg::RG_REGF;
					next_s.sel_stdio = (region == dsd_pkg::RG_STDIO) && !own;
					next_s.sel_xio   = region == dsd_pkg::RG_XIO;
					next_s.sel_sram  = region == dsd_pkg::RG_SRAM;
					next_s.mem_we    = we_i && (region != dsd_pkg::RG_EXT) &&
						!own;
					next_s.mem_wdata = wdata_i;
					next_s.ext_null  = (region == dsd_pkg::RG_EXT) && !s.ext_mem_enable;
					if (go_ext) begin
						// External strobes only for the external window
						next_s.state     = dsd_pkg::ST_EXT;
						next_s.ext_rd    = !we_i;
						next_s.ext_wr    = we_i;
						next_s.ext_addr  = eff_addr;
						next_s.ext_wdata = wdata_i;
						// Extra cycles: byte n+1, stack pair 2n+3
						next_s.cnt = pair_i ?
							`EXT_PAIR_BASE + {1'b0, s.wait_st, 1'b0} :
							`EXT_BYTE_BASE + {2'h0, s.wait_st};
					end else begin
						// Internal or disabled window: one more cycle
						next_s.state = dsd_pkg::ST_ACCESS;
					end
					if (own && we_i) begin
						case (eff_addr)
							`ADDR_MCU_CTRL: begin
								next_s.ext_mem_enable     = wdata_i[`MCU_SRE_BIT];
								next_s.wait_st =
									wdata_i[`MCU_WAIT_LSB +: 2];
							end
							`ADDR_EE_CTRL: begin
								next_s.rdy_ie = wdata_i[`EEC_RDY_IE_BIT];
								if (wdata_i[`EEC_ARM_BIT]) begin
									next_s.arm     = 1'b1;
									next_s.arm_cnt = `ARM_WINDOW;
								end
								// Strobe without arm does nothing
								if (wdata_i[`EEC_WR_BIT] && s.arm &&
									!eep_busy_i) begin
									next_s.eep_wr = 1'b1;
									next_s.hold   = `EE_WR_HOLD;
								end else if (wdata_i[`EEC_RD_BIT] &&
									!eep_busy_i) begin
									next_s.eep_rd = 1'b1;
									next_s.hold   = `EE_RD_HOLD;
								end
							end
							`ADDR_EE_DATA: begin
								next_s.eeprom_data_reg = wdata_i;
							end
							`ADDR_EE_ADDR_LO: begin
								if (!eep_busy_i) begin
									next_s.eeprom_addr_reg[7:0] = wdata_i;
								end
							end
							`ADDR_EE_ADDR_HI: begin
								if (!eep_busy_i) begin
									next_s.eeprom_addr_reg[11:8] = wdata_i[3:0];
								end
							end
							default: begin
								next_s.eeprom_addr_reg = s.eeprom_addr_reg;
							end
						endcase
					end
				end
			end
			dsd_pkg::ST_ACCESS: begin
				next_s.done      = 1'b1;
				next_s.state     = dsd_pkg::ST_IDLE;
				next_s.mem_we    = 1'b0;
				next_s.sel_regf  = 1'b0;
				next_s.sel_stdio = 1'b0;
				next_s.sel_xio   = 1'b0;
				next_s.sel_sram  = 1'b0;
				if (s.own_hit) begin
					next_s.rdata = own_rd;
				end else if (s.ext_null) begin
					next_s.rdata = 8'h00;
				end else begin
					next_s.rdata = int_rdata_i;
				end
			end
			dsd_pkg::ST_EXT: begin
				if (s.cnt == 4'h0) begin
					next_s.done   = 1'b1;
					next_s.state  = dsd_pkg::ST_IDLE;
					next_s.ext_rd = 1'b0;
					next_s.ext_wr = 1'b0;
					next_s.rdata  = s.is_rd ? ext_rdata_i : 8'h00;
				end else begin
					next_s.cnt = s.cnt - 4'h1;
				end
			end
			default: begin
				next_s.state = dsd_pkg::ST_IDLE;
			end
		endcase
		// Hold the core for EEPROM and external extra cycles
		next_s.stall = (next_s.hold != 3'h0) ||
			((next_s.state == dsd_pkg::ST_EXT) && (next_s.cnt != 4'h0));
	end

	// ----------------------------------------------------------------
	// State register; address comes up as zero, software must load it
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			s         <= '0;
			s.state   <= dsd_pkg::ST_IDLE;
			s.ext_mem_enable     <= 1'(`MCU_CTRL_RST >> `MCU_SRE_BIT);
			s.eeprom_addr_reg    <= `EEPROM_ADDR_REG_RST;
			s.eeprom_data_reg    <= `EEPROM_DATA_REG_RST;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign done_o        = s.done;
	assign stall_o       = s.stall;
	assign rdata_o       = s.rdata;
	assign ptr_wb_o      = s.ptr_wb;
	assign ptr_new_o     = s.ptr_new;
	assign sel_regfile_o = s.sel_regf;
	assign sel_std_io_o  = s.sel_stdio;
	assign sel_ext_io_o  = s.sel_xio;
	assign sel_sram_o    = s.sel_sram;
	assign local_addr_o  = s.laddr;
	assign mem_we_o      = s.mem_we;
	assign mem_wdata_o   = s.mem_wdata;
	assign ext_rd_o      = s.ext_rd;
	assign ext_wr_o      = s.ext_wr;
	assign ext_addr_o    = s.ext_addr;
	assign ext_wdata_o   = s.ext_wdata;
	assign eep_addr_o    = s.eeprom_addr_reg;
	assign eep_wdata_o   = s.eeprom_data_reg;
	assign eep_rd_o      = s.eep_rd;
	assign eep_wr_o      = s.eep_wr;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	sequence s_rd_hold;
		stall_o [*4] ##1 !stall_o;
	endsequence
	sequence s_wr_hold;
		stall_o [*2] ##1 !stall_o;
	endsequence
	sequence s_quiet2;
		(!ext_rd_o && !ext_wr_o) [*2];
	endsequence

	property p_int_time;
		take && !go_ext |-> ##1 !done_o ##1 done_o;
	endproperty
	a_int_time: assert property (p_int_time) else $error("int late");

	property p_int_quiet;
		take && (region != dsd_pkg::RG_EXT) |-> ##1 s_quiet2;
	endproperty
	a_int_quiet: assert property (p_int_quiet) else $error("strobe");

	property p_ext_w0;
		take && go_ext && !pair_i && (s.wait_st == 2'h0)
			|-> ##2 !done_o ##1 done_o;
	endproperty
	a_ext_w0: assert property (p_ext_w0) else $error("ext w0");

	property p_ext_w3;
		take && go_ext && !pair_i && (s.wait_st == 2'h3)
			|-> ##1 stall_o [*4] ##1 !done_o ##1 done_o;
	endproperty
	a_ext_w3: assert property (p_ext_w3) else $error("ext w3");

	property p_pair_w0;
		take && go_ext && pair_i && (s.wait_st == 2'h0)
			|-> ##1 stall_o [*3] ##1 (!stall_o && !done_o) ##1 done_o;
	endproperty
	a_pair_w0: assert property (p_pair_w0) else $error("pair w0");

	property p_pair_w1;
		take && go_ext && pair_i && (s.wait_st == 2'h1)
			|-> ##7 done_o;
	endproperty
	a_pair_w1: assert property (p_pair_w1) else $error("pair w1");

	property p_ext_off;
		take && (region == dsd_pkg::RG_EXT) && !s.ext_mem_enable && !we_i
			|-> ##1 s_quiet2 ##0 (done_o && rdata_o == 8'h00);
	endproperty
	a_ext_off: assert property (p_ext_off) else $error("ext off");

	property p_ee_rd;
		eep_rd_o |-> s_rd_hold;
	endproperty
	a_ee_rd: assert property (p_ee_rd) else $error("rd stall");

	property p_ee_wr;
		eep_wr_o |-> s_wr_hold ##0 $past(s.arm, 3);
	endproperty
	a_ee_wr: assert property (p_ee_wr) else $error("wr stall");

	property p_predec;
		take && !io_insn_i && (addr_mode_i == dsd_pkg::AM_PREDEC)
			|=> ptr_wb_o && (ptr_new_o == $past(ptr_base_i) - 16'h0001);
	endproperty
	a_predec: assert property (p_predec) else $error("predec");

	property p_io_short;
		take && io_insn_i |=> !sel_ext_io_o && !ext_rd_o && !ext_wr_o;
	endproperty
	a_io_short: assert property (p_io_short) else $error("io insn");

	property p_hi_zero;
		done_o && s.own_hit && (s.laddr == `ADDR_EE_ADDR_HI)
			|-> rdata_o[7:4] == 4'h0;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("hi bits");

endmodule : data_space_decoder_timing

//--- tb/ds_far_model.sv
// Far side model: internal memories, external SRAM, EEPROM array
`timescale 1ns/1ps

module ds_far_model (
	input  wire logic        core_clk_i,
	input  wire logic [15:0] local_addr_i,
	input  wire logic        ext_rd_i,
	input  wire logic        ext_wr_i,
	input  wire logic [15:0] ext_addr_i,
	input  wire logic [7:0]  ext_wdata_i,
	input  wire logic [11:0] eep_addr_i,
	output logic [7:0]       int_rdata_o,
	output logic [7:0]       ext_rdata_o,
	output logic [7:0]       eep_rdata_o
);
	logic [7:0] mem [256];
	logic [7:0] last = 8'h00;

	// Internal space and EEPROM array as address patterns
	assign int_rdata_o = local_addr_i[7:0] ^ 8'h5A;
	assign eep_rdata_o = eep_addr_i[7:0] ^ 8'hC3;
	// Released data lines show the inverse of the last byte
	assign ext_rdata_o = ext_rd_i ? mem[ext_addr_i[7:0]] : ~last;

	// External SRAM storage, one byte per strobe cycle
	always @(posedge core_clk_i) begin
		if (ext_wr_i)
			mem[ext_addr_i[7:0]] <= ext_wdata_i;
		if (ext_rd_i)
			last <= ext_rdata_o;
	end
endmodule : ds_far_model

//--- tb/tb_data_space_decoder_timing.sv
// Self-checking bench for the data space decoder
`timescale 1ns/1ps

module tb_data_space_decoder_timing;
	logic                core_clk_i    = 1'h0;
	logic                reset_i       = 1'h1;
	logic                compat_mode_i = 1'h0;
	logic                req_i         = 1'h0;
	logic                we_i          = 1'h0;
	logic                io_insn_i     = 1'h0;
	logic                pair_i        = 1'h0;
	logic                eep_busy_i    = 1'h0;
	dsd_pkg::addr_mode_t addr_mode_i   = dsd_pkg::AM_DIRECT;
	logic [1:0]          ptr_sel_i     = 2'h0;
	logic [15:0]         ptr_base_i    = 16'h0000;
	logic [15:0]         direct_addr_i = 16'h0000;
	logic [5:0]          disp_i        = 6'h00;
	logic [7:0]          wdata_i       = 8'h00;
	logic [7:0]          int_rdata_i, ext_rdata_i, eep_rdata_i, rdata_o;
	logic [7:0]          mem_wdata_o, ext_wdata_o, eep_wdata_o;
	logic                done_o, stall_o, ptr_wb_o, mem_we_o;
	logic                sel_regfile_o, sel_std_io_o, sel_ext_io_o;
	logic                sel_sram_o, ext_rd_o, ext_wr_o, eep_rd_o, eep_wr_o;
	logic [15:0]         ptr_new_o, local_addr_o, ext_addr_o, la, pn;
	logic [11:0]         eep_addr_o;
	logic [3:0]          sel;
	logic                ext, ewr, erd, pwb, mwe;
	logic [7:0]          mwd;
	int                  bad_count = 0, n_checks = 0, n, st, i, w, m;
	logic [15:0]         ta [9] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060,
		16'h00FF, 16'h0100, 16'h0FFF, 16'h10FF, 16'h1100};
	logic [3:0]          tn [9] = '{4'h8, 4'h4, 4'h4, 4'h2, 4'h2, 4'h1,
		4'h1, 4'h1, 4'h0};
	logic [3:0]          tc [9] = '{4'h8, 4'h4, 4'h4, 4'h1, 4'h1, 4'h1,
		4'h1, 4'h0, 4'h0};

	// Clock at 125 MHz
	always #4 core_clk_i = ~core_clk_i;

	data_space_decoder_timing dut (
		.core_clk_i, .reset_i, .compat_mode_i, .req_i, .we_i, .io_insn_i,
		.pair_i, .addr_mode_i, .ptr_sel_i, .ptr_base_i, .disp_i,
		.direct_addr_i, .wdata_i, .int_rdata_i, .ext_rdata_i, .eep_rdata_i,
		.eep_busy_i, .done_o, .stall_o, .rdata_o, .ptr_wb_o, .ptr_new_o,
		.sel_regfile_o, .sel_std_io_o, .sel_ext_io_o, .sel_sram_o,
		.local_addr_o, .mem_we_o, .mem_wdata_o, .ext_rd_o, .ext_wr_o,
		.ext_addr_o, .ext_wdata_o, .eep_addr_o, .eep_wdata_o, .eep_rd_o,
		.eep_wr_o);

	ds_far_model far (
		.core_clk_i, .local_addr_i(local_addr_o), .ext_rd_i(ext_rd_o),
		.ext_wr_i(ext_wr_o), .ext_addr_i(ext_addr_o),
		.ext_wdata_i(ext_wdata_o), .eep_addr_i(eep_addr_o),
		.int_rdata_o(int_rdata_i), .ext_rdata_o(ext_rdata_i),
		.eep_rdata_o(eep_rdata_i));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One access from a falling edge; records timing and strobes
	task xfer(input logic wr, input logic [15:0] a, input logic [7:0] d);
		int k;
		{req_i, we_i, direct_addr_i, wdata_i} = {1'h1, wr, a, d};
		{n, st, sel, ext, ewr, erd, pwb} = '0;
		@(negedge core_clk_i);
		req_i = 1'h0;
		for (k = 1; k < 40; k++) begin
			if (k == 1) begin
				sel = {sel_regfile_o, sel_std_io_o, sel_ext_io_o, sel_sram_o};
				{la, pwb, pn} = {local_addr_o, ptr_wb_o, ptr_new_o};
				{mwe, mwd} = {mem_we_o, mem_wdata_o};
			end
			ext |= ext_rd_o | ext_wr_o;
			ewr |= eep_wr_o;
			erd |= eep_rd_o;
			st += stall_o;
			if (done_o === 1'h1)
				n = k;
			if (n != 0 && stall_o === 1'h0)
				break;
			@(negedge core_clk_i);
		end
	endtask : xfer

	task wrap_up;
		if (bad_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up

	// Watchdog
	initial begin
		#400000;
		bad_count++;
		wrap_up();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(negedge core_clk_i);
		reset_i = 1'h0;
		xfer(1'h0, 16'h003F, 8'h00);
		chk(rdata_o, 16'h0000);
		// Region map, external disabled, normal then legacy
		for (m = 0; m < 2; m++) begin
			for (i = 0; i < 9; i++) begin
				xfer(1'h0, ta[i], 8'h00);
				chk(sel, m ? tc[i] : tn[i]);
				chk(n, 2);
				chk(ext, 0);
				chk(rdata_o, sel ? ta[i][7:0] ^ 8'h5A : 8'h00);
			end
			compat_mode_i = 1'h1;
			repeat (3) @(negedge core_clk_i);
		end
		compat_mode_i = 1'h0;
		repeat (3) @(negedge core_clk_i);
		// Short I/O instruction index never reaches extended I/O
		io_insn_i = 1'h1;
		xfer(1'h0, 16'h00FF, 8'h00);
		io_insn_i = 1'h0;
		chk(sel, 4'h4);
		chk(la, 16'h005F);
		// External access with each wait-state setting
		for (w = 0; w < 4; w++) begin
			xfer(1'h1, 16'h0055, 8'h80 | (w << 2));
			xfer(1'h0, 16'h0055, 8'h00);
			chk(rdata_o, 8'h80 | (w << 2));
			xfer(1'h1, 16'h1100 + w, 8'hA0 + w);
			chk(n, 3 + w);
			chk(st, 1 + w);
			chk(ext, 1);
			xfer(1'h0, 16'h1100 + w, 8'h00);
			chk(rdata_o, 8'hA0 + w);
			pair_i = 1'h1;
			xfer(1'h0, 16'h1100, 8'h00);
			pair_i = 1'h0;
			chk(n, 5 + 2 * w);
		end
		xfer(1'h1, 16'h0055, 8'h00);
		chk(mwe, 0);
		xfer(1'h1, 16'h0100, 8'h77);
		chk({mwe, mwd}, {1'h1, 8'h77});
		// Pointer addressing modes
		addr_mode_i = dsd_pkg::AM_DISP;
		{ptr_sel_i, ptr_base_i} = 18'h10200;
		disp_i = 6'h3F;
		xfer(1'h0, 16'h0000, 8'h00);
		chk(la, 16'h023F);
		ptr_sel_i = 2'h0;
		xfer(1'h0, 16'h0000, 8'h00);
		chk(la, 16'h0200);
		addr_mode_i = dsd_pkg::AM_PREDEC;
		ptr_base_i = 16'h0300;
		xfer(1'h0, 16'h0000, 8'h00);
		chk({la, pn}, {16'h02FF, 16'h02FF});
		chk(pwb, 1);
		addr_mode_i = dsd_pkg::AM_POSTINC;
		xfer(1'h0, 16'h0000, 8'h00);
		chk({la, pn}, {16'h0300, 16'h0301});
		addr_mode_i = dsd_pkg::AM_DIRECT;
		// EEPROM address, data and read
		xfer(1'h1, 16'h003F, 8'hFF);
		xfer(1'h1, 16'h003E, 8'hA5);
		xfer(1'h0, 16'h003F, 8'h00);
		chk(rdata_o, 8'h0F);
		chk(eep_addr_o, 12'hFA5);
		eep_busy_i = 1'h1;
		xfer(1'h1, 16'h003E, 8'h00);
		eep_busy_i = 1'h0;
		chk(eep_addr_o, 12'hFA5);
		xfer(1'h1, 16'h003C, 8'h01);
		chk({erd, st[15:0]}, {1'h1, 16'h0004});
		xfer(1'h0, 16'h003D, 8'h00);
		chk(rdata_o, 8'hA5 ^ 8'hC3);
		// EEPROM write: strobe alone, armed, after arm expiry
		xfer(1'h1, 16'h003D, 8'h3C);
		chk(eep_wdata_o, 8'h3C);
		xfer(1'h1, 16'h003C, 8'h02);
		chk(ewr, 0);
		xfer(1'h1, 16'h003C, 8'h04);
		xfer(1'h1, 16'h003C, 8'h02);
		chk({ewr, st[15:0]}, {1'h1, 16'h0002});
		xfer(1'h1, 16'h003C, 8'h04);
		repeat (6) @(negedge core_clk_i);
		xfer(1'h1, 16'h003C, 8'h02);
		chk(ewr, 0);
		wrap_up();
	end
endmodule : tb_data_space_decoder_timing
